// ===== ccd_pkg.sv
// shared constants and carriers for the pixel correction pipeline
package ccd_pkg;
	localparam int PIX_W = 12;
	localparam int GAIN_W = 12;
	localparam int OFS_PIN_W = 8;
	localparam int OFS_W = 10;
	localparam int MPU_W = 8;
	localparam int HIST_D = 6;
	localparam int ADDR_W = 6;
	localparam logic [11:0] PIX_MAX = 12'hfff;
	localparam logic [11:0] GMASK_10 = 12'hffc;
	localparam logic [11:0] GMASK_11 = 12'hffe;
	localparam logic [11:0] GMASK_12 = 12'hfff;
	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_CFG1 = 4'h0;
	localparam logic [3:0] IDX_CFG2 = 4'h1;
	localparam logic [3:0] IDX_ODD = 4'h3;
	localparam logic [3:0] IDX_EVEN = 4'h4;
	localparam logic [3:0] IDX_BAYER = 4'h7;
	localparam logic [3:0] IDX_STATUS = 4'h8;
	// field positions
	localparam int CFG1_SCALE_LO = 0;
	localparam int CFG1_PIN_LO = 3;
	localparam int CFG1_PTR_LO = 6;
	localparam int CFG2_CDS = 0;
	localparam int CFG2_ONE = 1;
	localparam int BAYER_EN = 0;
	// pipeline timing in conversion clock cycles
	localparam logic [3:0] LAT_THREE = 4'h9;
	localparam logic [3:0] LAT_ONE = 4'h7;
	localparam int OUT_LAT = 6;
	localparam logic [3:0] GAIN_TAP_BASE = 4'h4;
	localparam logic [3:0] OFS_TAP_BASE = 4'h5;
	typedef enum logic [1:0] {
		RED = 2'b00,
		GREEN = 2'b01,
		BLUE = 2'b10,
		CH_NONE = 2'b11
	} chan_t;
	typedef enum logic [2:0] {
		THREE_CDS = 3'b000,
		THREE_SHA = 3'b001,
		ONE_CDS = 3'b010,
		ONE_SHA = 3'b011,
		BAYER = 3'b100
	} mode_t;
	typedef struct packed {
		logic [PIX_W-1:0] data;
		chan_t ch;
		logic odd;
	} pixel_t;
endpackage

// ===== gain_apply.sv
// per-pixel digital gain multiplier with saturation
`timescale 1ns/1ps
module gain_apply (
	input wire logic [11:0] diff,
	input wire logic [11:0] gain,
	input wire logic [2:0] scale,
	output logic [11:0] result
);
	logic [2:0] mult_x;
	logic [26:0] prod;
	logic [15:0] sum;

	// x of 7, 3 or 1 gives a top gain of 8, 4 or 2
	assign mult_x = scale[2] ? 3'h7 : (scale[1] ? 3'h3 : (scale[0] ? 3'h1 : 3'h0));
	assign prod = 27'(diff) * 27'(gain) * 27'(mult_x);
	// zero word adds nothing, unity gain
	assign sum = {4'h0, diff} + {1'b0, prod[26:12]};

	always_comb
	begin
		if (scale == 3'h0)
			result = diff;
		else if (sum > {4'h0, ccd_pkg::PIX_MAX})
			result = ccd_pkg::PIX_MAX;
		else
			result = sum[11:0];
	end
endmodule

// ===== pixel_pipe.sv
// pixel sequencing, odd/even, offset and gain correction with register access
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module pixel_pipe (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [5:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic LINE_START,
	input wire logic [11:0] ADC_DATA,
	input wire logic [11:0] GAIN_WORD,
	input wire logic [7:0] OFFSET_WORD,
	input wire logic CHIP_SELECT_N,
	input wire logic WRITE_STROBE_N,
	input wire logic READ_STROBE_N,
	input wire logic [2:0] HOST_ADDR,
	input wire logic [7:0] DOUT_I,
	output logic [11:0] DOUT_O,
	output logic [11:0] DOUT_OE,
	output logic [1:0] MUX_SELECT,
	output logic [1:0] PIXEL_CHANNEL,
	output logic CDS_ENABLE
);
	typedef struct packed {
		logic ls1;
		logic ls2;
		logic ls3;
		logic [11:0] adc1;
		logic [11:0] adc2;
		logic [11:0] g1;
		logic [11:0] g2;
		logic [7:0] o1;
		logic [7:0] o2;
		logic [5:0][11:0] ghist;
		logic [5:0][7:0] ohist;
		logic csn1;
		logic csn2;
		logic wrn1;
		logic wrn2;
		logic wrn3;
		logic rdn1;
		logic rdn2;
		logic [2:0] ha1;
		logic [2:0] ha2;
		logic [7:0] hd1;
		logic [7:0] hd2;
		logic [7:0] cfg1;
		logic [7:0] cfg2;
		logic bayer_en;
		logic line_type;
		logic [2:0][7:0] odd_ofs;
		logic [2:0][7:0] even_ofs;
		ccd_pkg::chan_t chan;
		logic odd;
		ccd_pkg::pixel_t t1;
		ccd_pkg::pixel_t raw;
		ccd_pkg::pixel_t oe;
		ccd_pkg::pixel_t sub;
		ccd_pkg::pixel_t mul;
		logic [11:0] dout_o;
		logic [11:0] dout_oe;
		ccd_pkg::chan_t out_ch;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_t;

	localparam state_t STATE_RST = '0;

	state_t s;
	state_t next_s;
	ccd_pkg::mode_t mode;
	logic three_ch;
	logic one_ch;
	logic [3:0] lat;
	logic [2:0] gtap;
	logic [2:0] otap;
	logic [2:0] pin;
	logic [11:0] gmask;
	logic [11:0] gain_eff;
	logic [9:0] ofs_word;
	logic sub_en;
	logic [7:0] oe_corr;
	logic [13:0] oe_sum;
	logic [11:0] oe_val;
	logic [12:0] sub_diff;
	logic [11:0] mult_res;
	logic [3:0] apb_idx;
	logic apb_mapped;
	logic apb_wr;
	logic host_wr;
	logic wr_en;
	logic [3:0] wr_idx;
	logic [7:0] wr_data;
	logic host_rd;
	logic host_wr_act;
	ccd_pkg::chan_t ptr;

	function automatic logic [7:0] reg_val(input logic [3:0] idx, input state_t st);
		logic [1:0] p;
		p = st.cfg1[ccd_pkg::CFG1_PTR_LO +: 2];
		case (idx)
			ccd_pkg::IDX_CFG1: reg_val = st.cfg1;
			ccd_pkg::IDX_CFG2: reg_val = st.cfg2;
			ccd_pkg::IDX_ODD: reg_val = (p == 2'h3) ? 8'h00 : st.odd_ofs[p];
			ccd_pkg::IDX_EVEN: reg_val = (p == 2'h3) ? 8'h00 : st.even_ofs[p];
			ccd_pkg::IDX_BAYER: reg_val = {7'h00, st.bayer_en};
			ccd_pkg::IDX_STATUS: reg_val = {3'h0, st.line_type, st.odd, st.chan, st.ls2};
			default: reg_val = 8'h00;
		endcase
	endfunction

	// mode from bayer enable, one-channel and CDS bits
	// one-channel bit picks single input operation
	assign mode = s.bayer_en ? ccd_pkg::BAYER :
		ccd_pkg::mode_t'({1'b0, s.cfg2[ccd_pkg::CFG2_ONE], ~s.cfg2[ccd_pkg::CFG2_CDS]});
	assign three_ch = (mode == ccd_pkg::THREE_CDS) || (mode == ccd_pkg::THREE_SHA);
	assign one_ch = (mode == ccd_pkg::ONE_CDS) || (mode == ccd_pkg::ONE_SHA);
	assign ptr = (s.cfg1[ccd_pkg::CFG1_PTR_LO +: 2] == 2'h3) ? ccd_pkg::RED :
		ccd_pkg::chan_t'(s.cfg1[ccd_pkg::CFG1_PTR_LO +: 2]);

	// gain/offset taps give latency 9 in the three-channel modes, 7 in one-channel and bayer
	assign lat = three_ch ? ccd_pkg::LAT_THREE : ccd_pkg::LAT_ONE;
	assign gtap = 3'(lat - ccd_pkg::GAIN_TAP_BASE);
	assign otap = 3'(lat - ccd_pkg::OFS_TAP_BASE);

	// gain width 10, 11 or 12 by pin distribution
	// masked lsbs coarsen the step count
	assign pin = s.cfg1[ccd_pkg::CFG1_PIN_LO +: 3];
	assign gmask = pin[0] ? ccd_pkg::GMASK_10 : (pin[1] ? ccd_pkg::GMASK_11 : ccd_pkg::GMASK_12);
	assign gain_eff = s.ghist[gtap] & gmask;
	// gain lsbs become offset msbs for 10 and 9 bit widths
	// straight binary, unit steps up to 1023
	assign ofs_word = pin[0] ? {s.ghist[otap][1:0], s.ohist[otap]} :
		(pin[1] ? {1'b0, s.ghist[otap][0], s.ohist[otap]} : {2'h0, s.ohist[otap]});
	// no pin distribution bit bypasses the subtracter
	assign sub_en = |pin;

	// odd/even correction first, twos complement trim
	assign oe_corr = s.raw.odd ? s.odd_ofs[s.raw.ch] : s.even_ofs[s.raw.ch];
	assign oe_sum = {2'h0, s.raw.data} + {{6{oe_corr[7]}}, oe_corr};
	assign oe_val = oe_sum[13] ? 12'h000 : (oe_sum[12] ? ccd_pkg::PIX_MAX : oe_sum[11:0]);
	// offset subtracted after odd/even, clamped at zero
	assign sub_diff = {1'b0, s.oe.data} - {3'h0, ofs_word};

	gain_apply u_gain (
		.diff(s.sub.data),
		.gain(gain_eff),
		.scale(s.cfg1[ccd_pkg::CFG1_SCALE_LO +: 3]),
		.result(mult_res)
	);

	assign apb_idx = PADDR[5:2];
	assign apb_mapped = (apb_idx == ccd_pkg::IDX_CFG1) || (apb_idx == ccd_pkg::IDX_CFG2) ||
		(apb_idx == ccd_pkg::IDX_ODD) || (apb_idx == ccd_pkg::IDX_EVEN) ||
		(apb_idx == ccd_pkg::IDX_BAYER) || (apb_idx == ccd_pkg::IDX_STATUS);
	assign apb_wr = PSEL && PENABLE && PWRITE && s.pready && apb_mapped;
	// host write lands on the rising edge of its strobe
	assign host_wr = !s.csn2 && s.wrn2 && !s.wrn3;
	assign wr_en = apb_wr || host_wr;
	assign wr_idx = apb_wr ? apb_idx : {1'b0, s.ha2};
	assign wr_data = apb_wr ? PWDATA[7:0] : s.hd2;
	assign host_rd = !s.csn2 && !s.rdn2;
	assign host_wr_act = !s.csn2 && !s.wrn2;

	always_comb
	begin
		next_s = s;
		// gain word captured each edge, two flops deep
		next_s.g1 = GAIN_WORD;
		next_s.g2 = s.g1;
		// offset word captured each edge likewise
		next_s.o1 = OFFSET_WORD;
		next_s.o2 = s.o1;
		next_s.ghist = {s.ghist[4:0], s.g2};
		next_s.ohist = {s.ohist[4:0], s.o2};
		next_s.ls1 = LINE_START;
		next_s.ls2 = s.ls1;
		next_s.ls3 = s.ls2;
		next_s.adc1 = ADC_DATA;
		next_s.adc2 = s.adc1;
		next_s.csn1 = CHIP_SELECT_N;
		next_s.csn2 = s.csn1;
		next_s.wrn1 = WRITE_STROBE_N;
		next_s.wrn2 = s.wrn1;
		next_s.wrn3 = s.wrn2;
		next_s.rdn1 = READ_STROBE_N;
		next_s.rdn2 = s.rdn1;
		next_s.ha1 = HOST_ADDR;
		next_s.ha2 = s.ha1;
		next_s.hd1 = DOUT_I;
		next_s.hd2 = s.hd1;

		if (wr_en)
		begin
			case (wr_idx)
				ccd_pkg::IDX_CFG1: next_s.cfg1 = wr_data;
				ccd_pkg::IDX_CFG2: next_s.cfg2 = wr_data;
				ccd_pkg::IDX_ODD:
				begin
					if (s.cfg1[ccd_pkg::CFG1_PTR_LO +: 2] != 2'h3)
						next_s.odd_ofs[s.cfg1[ccd_pkg::CFG1_PTR_LO +: 2]] = wr_data;
				end
				ccd_pkg::IDX_EVEN:
				begin
					if (s.cfg1[ccd_pkg::CFG1_PTR_LO +: 2] != 2'h3)
						next_s.even_ofs[s.cfg1[ccd_pkg::CFG1_PTR_LO +: 2]] = wr_data;
				end
				ccd_pkg::IDX_BAYER:
				begin
					next_s.bayer_en = wr_data[ccd_pkg::BAYER_EN];
					// writing one restarts on a green-blue line
					if (wr_data[ccd_pkg::BAYER_EN])
						next_s.line_type = 1'b0;
				end
				default: next_s.cfg1 = s.cfg1;
			endcase
		end
		else if (mode == ccd_pkg::BAYER && s.ls3 && !s.ls2)
			next_s.line_type = ~s.line_type;

		case (mode)
			ccd_pkg::THREE_CDS, ccd_pkg::THREE_SHA:
			begin
				// line start low: red, even expected
				// so red is first after line start
				if (!s.ls2)
				begin
					next_s.chan = ccd_pkg::RED;
					next_s.odd = 1'b0;
				end
				else
				begin
					case (s.chan)
						ccd_pkg::RED: next_s.chan = ccd_pkg::GREEN;
						ccd_pkg::GREEN: next_s.chan = ccd_pkg::BLUE;
						default: next_s.chan = ccd_pkg::RED;
					endcase
					if (s.chan == ccd_pkg::BLUE)
						next_s.odd = ~s.odd;
				end
			end
			ccd_pkg::ONE_CDS, ccd_pkg::ONE_SHA:
			begin
				next_s.chan = ptr;
				next_s.odd = s.ls2 ? ~s.odd : 1'b0;
			end
			default:
			begin
				// bayer: all even, green/blue alternate, line type picks the first
				next_s.odd = 1'b0;
				if (!s.ls2)
					next_s.chan = s.line_type ? ccd_pkg::BLUE : ccd_pkg::GREEN;
				else
					next_s.chan = (s.chan == ccd_pkg::GREEN) ?
						(s.line_type ? ccd_pkg::BLUE : ccd_pkg::BLUE) : ccd_pkg::GREEN;
			end
		endcase

		// tags ride beside the data stage by stage
		next_s.t1 = '{data: 12'h000, ch: s.chan, odd: s.odd};
		next_s.raw = '{data: s.adc2, ch: s.t1.ch, odd: s.t1.odd};
		next_s.oe = '{data: oe_val, ch: s.raw.ch, odd: s.raw.odd};
		next_s.sub = s.oe;
		if (sub_en)
			next_s.sub.data = sub_diff[12] ? 12'h000 : sub_diff[11:0];
		next_s.mul = s.sub;
		next_s.mul.data = mult_res;
		next_s.out_ch = s.mul.ch;

		// pixels out, low byte serves the host during strobes
		next_s.dout_o = s.mul.data;
		next_s.dout_oe = ccd_pkg::PIX_MAX;
		if (host_rd)
			next_s.dout_o[7:0] = reg_val({1'b0, s.ha2}, s);
		else if (host_wr_act)
			next_s.dout_oe[7:0] = 8'h00;

		next_s.pready = PSEL && PENABLE && !s.pready;
		next_s.pslverr = PSEL && PENABLE && !s.pready && !apb_mapped;
		if (PSEL && PENABLE && !s.pready)
			next_s.prdata = {24'h000000, reg_val(apb_idx, s)};
	end

	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			s <= STATE_RST;
		else
			s <= next_s;
	end

	assign PRDATA = s.prdata;
	assign PREADY = s.pready;
	assign PSLVERR = s.pslverr;
	assign DOUT_O = s.dout_o;
	assign DOUT_OE = s.dout_oe;
	assign MUX_SELECT = s.chan;
	assign PIXEL_CHANNEL = s.out_ch;
	// clear CDS bit tells the front end to sample-and-hold
	assign CDS_ENABLE = s.cfg2[ccd_pkg::CFG2_CDS];

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESET_N);

	a_ready_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY && !$past(PREADY))
		else $error("apb access not answered in one cycle");
	a_ready_single: assert property (PREADY |=> !PREADY)
		else $error("pready held longer than one cycle");
	a_line_red: assert property (three_ch && !s.ls2 && !wr_en |=> s.chan == ccd_pkg::RED && !s.odd)
		else $error("line start low did not select red even");
	a_rgb_order: assert property (three_ch && s.ls2 && s.chan == ccd_pkg::RED && !wr_en
		##1 three_ch && s.ls2 && !wr_en |=> s.chan == ccd_pkg::BLUE)
		else $error("channel order not red green blue");
	a_set_toggle: assert property (three_ch && s.ls2 && s.chan == ccd_pkg::BLUE && !wr_en
		|=> s.odd != $past(s.odd) && s.chan == ccd_pkg::RED)
		else $error("odd/even not flipped after blue");
	a_one_fixed: assert property (one_ch && !wr_en |=> s.chan == $past(ptr))
		else $error("one-channel mux left the pointer input");
	a_pixel_alt: assert property (one_ch && s.ls2 && !wr_en |=> s.odd != $past(s.odd))
		else $error("one-channel pixels do not alternate");
	a_out_latency: assert property (PIXEL_CHANNEL == $past(s.chan, 6))
		else $error("output tag not six cycles after sampling");
	a_sub_bypass: assert property (!sub_en && !wr_en |=> s.sub.data == $past(s.oe.data))
		else $error("subtracter not bypassed");
	a_sub_apply: assert property (sub_en && !sub_diff[12] && !wr_en
		|=> s.sub.data == 12'($past(s.oe.data) - 12'($past(ofs_word))))
		else $error("offset word not subtracted");
	a_mult_bypass: assert property (s.cfg1[2:0] == 3'h0 |-> mult_res == s.sub.data)
		else $error("multiplier not bypassed");
	a_unity_gain: assert property (gain_eff == 12'h000 |-> mult_res == s.sub.data)
		else $error("zero gain word not unity");

	c_three_set: cover property (three_ch && s.ls2 && s.chan == ccd_pkg::BLUE ##1 s.odd);
	c_one_chan: cover property (one_ch && s.ls2 ##1 s.odd);
	c_bayer_line: cover property (mode == ccd_pkg::BAYER && s.ls3 && !s.ls2);
	c_host_read: cover property (host_rd ##1 DOUT_OE == ccd_pkg::PIX_MAX);
endmodule

// ===== ctrl_model.sv
// far-side scanner controller: presents converter, gain and offset words
`timescale 1ns/1ps
module ctrl_model (
	input wire logic clk,
	input wire logic [11:0] adc_req,
	input wire logic [11:0] gain_req,
	input wire logic [7:0] ofs_req,
	output logic [11:0] adc_data = 12'h000,
	output logic [11:0] gain_word = 12'h000,
	output logic [7:0] offset_word = 8'h00
);
	// sample clocks not modelled, words change only after an edge
	always @(posedge clk)
	begin
		adc_data <= adc_req;
		gain_word <= gain_req;
		offset_word <= ofs_req;
	end
endmodule

// ===== tb.sv
// self-checking bench for the pixel correction pipeline
`timescale 1ns/1ps
`define CHK(name, exp, got) \
	begin \
		check_count++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("[FAIL] %s expected %h seen %h", name, exp, got); \
		end \
	end
module tb;
	logic MCLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, LINE_START = 0;
	logic [5:0] PADDR = 6'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic PREADY, PSLVERR, CDS_ENABLE, err;
	logic [11:0] ADC_DATA, GAIN_WORD, DOUT_O, DOUT_OE;
	logic [7:0] OFFSET_WORD, rd, cfg;
	logic [7:0] DOUT_I = 8'h00, host_byte = 8'h00;
	logic CHIP_SELECT_N = 1, WRITE_STROBE_N = 1, READ_STROBE_N = 1;
	logic [2:0] HOST_ADDR = 3'h0;
	logic [1:0] MUX_SELECT, PIXEL_CHANNEL;
	logic [11:0] adc_req = 12'h000, gain_req = 12'h000;
	logic [7:0] ofs_req = 8'h00;
	int fail_count = 0, check_count = 0, seed = 32'hc740, n, k;

	ctrl_model far (.clk(MCLK), .adc_req, .gain_req, .ofs_req, .adc_data(ADC_DATA), .gain_word(GAIN_WORD),
		.offset_word(OFFSET_WORD));
	pixel_pipe dut (.MCLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
		.LINE_START, .ADC_DATA, .GAIN_WORD, .OFFSET_WORD, .CHIP_SELECT_N, .WRITE_STROBE_N, .READ_STROBE_N,
		.HOST_ADDR, .DOUT_I, .DOUT_O, .DOUT_OE, .MUX_SELECT, .PIXEL_CHANNEL, .CDS_ENABLE);

	always #25 MCLK = ~MCLK;
	// host side of the shared bus floats to a changing pattern when not selected
	always @(posedge MCLK)
		DOUT_I <= CHIP_SELECT_N ? 8'($random(seed)) : host_byte;

	task automatic close_out();
		if (fail_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic timeout();
		fail_count++;
		$display("[FAIL] wait expected done seen timeout");
		close_out();
	endtask

	// model of the correction chain
	function automatic int expect_pix(int d, int g, int o, logic [7:0] c);
		int x;
		int ofs;
		x = c[2] ? 7 : c[1] ? 3 : c[0] ? 1 : 0;
		ofs = c[3] ? ((g & 3) << 8) | o : c[4] ? ((g & 1) << 8) | o : c[5] ? o : 0;
		g = c[3] ? g & 'hffc : c[4] ? g & 'hffe : g;
		d = d > ofs ? d - ofs : 0;
		d = d + ((d * g * x) >> 12);
		return d > 4095 ? 4095 : d;
	endfunction

	task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd, output logic [7:0] r,
		output logic e);
		int c;
		@(posedge MCLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= {idx, 2'b00};
		PWDATA <= {24'h0, wd};
		@(posedge MCLK);
		PENABLE <= 1'b1;
		c = 0;
		do
		begin
			@(posedge MCLK);
			c++;
		end
		while (PREADY !== 1'b1 && c < 20);
		if (c == 20)
			timeout();
		r = PRDATA[7:0];
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic host(input logic wr, input logic [2:0] a, input logic [7:0] b);
		@(posedge MCLK);
		HOST_ADDR <= a;
		host_byte <= b;
		CHIP_SELECT_N <= 1'b0;
		WRITE_STROBE_N <= !wr;
		READ_STROBE_N <= wr;
		repeat (4) @(posedge MCLK);
		#1;
		if (wr)
			`CHK("host write bus release", 8'h00, DOUT_OE[7:0])
		else
			`CHK("host read byte", b, DOUT_O[7:0])
		@(posedge MCLK);
		WRITE_STROBE_N <= 1'b1;
		READ_STROBE_N <= 1'b1;
		repeat (4) @(posedge MCLK);
		CHIP_SELECT_N <= 1'b1;
		repeat (4) @(posedge MCLK);
	endtask

	task automatic measure(input int exp, input string what);
		logic [11:0] old;
		int c;
		old = DOUT_O;
		c = 0;
		do
		begin
			@(posedge MCLK);
			#1;
			c++;
		end
		while (DOUT_O === old && c < 30);
		`CHK(what, exp, c)
	endtask

	initial
	begin
		repeat (20) @(posedge MCLK);
		RESET_N <= 1'b1;
		LINE_START <= 1'b1;
		apb(1'b0, ccd_pkg::IDX_CFG1, 8'h00, rd, err);
		`CHK("cfg1 reset", 8'h00, rd)
		apb(1'b0, ccd_pkg::IDX_CFG2, 8'h00, rd, err);
		`CHK("cfg2 reset", 8'h00, rd)
		apb(1'b0, 4'h2, 8'h00, rd, err);
		`CHK("unmapped error", 1'b1, err)
		`CHK("unmapped data", 8'h00, rd)
		apb(1'b1, ccd_pkg::IDX_CFG1, 8'h25, rd, err);
		host(1'b0, 3'h0, 8'h25);
		host(1'b1, 3'h1, 8'h01);
		`CHK("bus driven", 12'hfff, DOUT_OE)
		apb(1'b0, ccd_pkg::IDX_CFG2, 8'h00, rd, err);
		`CHK("host written cfg2", 8'h01, rd)
		// offset word and converter latency in all four sampling modes
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, ccd_pkg::IDX_CFG2, 8'(m), rd, err);
			apb(1'b1, ccd_pkg::IDX_CFG1, 8'ha0, rd, err);
			@(posedge MCLK);
			adc_req <= 12'h300;
			ofs_req <= 8'h00;
			repeat (16) @(posedge MCLK);
			ofs_req <= 8'h10;
			measure(int'(m[1] ? ccd_pkg::LAT_ONE : ccd_pkg::LAT_THREE) + 2, "word latency");
			@(posedge MCLK);
			adc_req <= 12'h320;
			measure(ccd_pkg::OUT_LAT + 2, "pixel latency");
			`CHK("cds enable", m[0], CDS_ENABLE)
			if (m[1])
				`CHK("one channel mux", 2'(ccd_pkg::BLUE), MUX_SELECT)
		end
		// every pin distribution against every scaling setting
		apb(1'b1, ccd_pkg::IDX_CFG2, 8'h00, rd, err);
		for (int p = 0; p < 4; p++)
			for (int s = 0; s < 4; s++)
			begin
				cfg = 8'((p == 0 ? 0 : 4 << p) | (s == 3 ? 4 : s));
				apb(1'b1, ccd_pkg::IDX_CFG1, cfg, rd, err);
				@(posedge MCLK);
				adc_req <= 12'($random(seed));
				gain_req <= s == 2 ? 12'h000 : 12'($random(seed));
				ofs_req <= 8'($random(seed));
				repeat (16) @(posedge MCLK);
				#1;
				`CHK("corrected pixel", 12'(expect_pix(adc_req, gain_req, ofs_req, cfg)), DOUT_O)
			end
		// odd and even correction of red across a fresh line
		apb(1'b1, ccd_pkg::IDX_CFG1, 8'h00, rd, err);
		apb(1'b1, ccd_pkg::IDX_ODD, 8'h05, rd, err);
		apb(1'b1, ccd_pkg::IDX_EVEN, 8'hfd, rd, err);
		@(posedge MCLK);
		adc_req <= 12'h400;
		LINE_START <= 1'b0;
		repeat (8) @(posedge MCLK);
		#1;
		`CHK("line start mux", 2'(ccd_pkg::RED), MUX_SELECT)
		@(posedge MCLK);
		LINE_START <= 1'b1;
		n = 0;
		do
		begin
			@(posedge MCLK);
			#1;
			n++;
		end
		while (MUX_SELECT !== 2'(ccd_pkg::GREEN) && n < 20);
		if (n == 20)
			timeout();
		for (int j = 0; j < 17; j++)
		begin
			`CHK("mux step", 2'((j + 1) % 3), MUX_SELECT)
			if (j >= 5)
			begin
				k = j - 5;
				`CHK("pixel tag", 2'(k % 3), PIXEL_CHANNEL)
				`CHK("pixel value", 12'(k % 3 != 0 ? 'h400 : (k / 3) % 2 ? 'h405 : 'h3fd), DOUT_O)
			end
			@(posedge MCLK);
			#1;
		end
		// bayer enable written while line start is held low starts on green
		@(posedge MCLK);
		LINE_START <= 1'b0;
		repeat (6) @(posedge MCLK);
		apb(1'b1, ccd_pkg::IDX_BAYER, 8'h01, rd, err);
		repeat (4) @(posedge MCLK);
		#1;
		`CHK("bayer first green", 2'(ccd_pkg::GREEN), MUX_SELECT)
		close_out();
	end
endmodule
